/* logic/lcdhp_consts.vh */
// Constants for the LCD host port and bias instruction block.
// Assumes inclusion by lcdhp_top.v only; definitions only.
`ifndef LCDHP_CONSTS_VH
`define LCDHP_CONSTS_VH

// Instruction opcodes, upper bits of an instruction byte
`define LCDHP_TEMP_OPC 6'h04
`define LCDHP_MULT_OPC 6'h10
`define LCDHP_FSET_OPC 3'h1
`define LCDHP_ICON_OPC 5'h01

// Field positions
`define LCDHP_VF_MSB 7
`define LCDHP_VF_SEL 6
`define LCDHP_FSET_DL 4
`define LCDHP_FSET_EXT 0
`define LCDHP_ICON_IM 2
`define LCDHP_I2C_CTL_RS 6

// Serial slave address, upper six bits; bit 1 comes from the strap
`define LCDHP_SLAVE_ADDR_HI 6'h1d

// Reset values, and the forbidden multiplier stage code
`define LCDHP_TC_RST 2'h0
`define LCDHP_STAGE_RST 2'h0
`define LCDHP_STAGE_FORBID 2'h3
`define LCDHP_VF_RST 6'h00
`define LCDHP_BUS8_RST 1'h1

// Queue between the host ports and the decoder
`define LCDHP_FIFO_W 10
`define LCDHP_FIFO_D 16
`define LCDHP_FIFO_AW 4

`endif

/* logic/lcdhp_top.v */
// Host ports (parallel 4/8-bit and two-wire serial slave), byte queue and
// extended-set decoder for temperature, multiplier and voltage factors.
// Assumes clk at 100 MHz; pins are asynchronous and synchronised here;
// display_on, power_down and std_ready come from logic on clk.
`timescale 1ns/10ps
`include "lcdhp_consts.vh"

module lcdhp_fifo #(
    parameter W = 10,
    parameter D = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire sys_rst,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    assign in_ready = (count_r != D[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= (wr_ptr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= (rd_ptr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

module lcdhp_top (
    input wire clk,
    input wire sys_rst,
    input wire parallel_strobe,
    input wire instr_data_select,
    input wire par_read_write,
    input wire [7:0] parallel_data_bus_in,
    output reg [7:0] parallel_data_bus_out,
    output reg parallel_data_bus_oe,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire addr_low_strap,
    input wire display_on,
    input wire power_down,
    input wire std_ready,
    output reg std_instr_valid,
    output reg [7:0] std_instr_byte,
    output reg std_instr_rs,
    output reg std_instr_rw,
    output reg [1:0] temp_coeff_sel,
    output reg [1:0] multiplier_stage_sel,
    output reg [5:0] char_mode_voltage_factor,
    output reg [5:0] icon_mode_voltage_factor,
    output reg icon_only_select,
    output reg extended_set_select,
    output reg bus_8bit,
    output reg [5:0] lcd_drive_voltage_out,
    output reg vgen_enable,
    output reg busy_flag
);
    localparam S_IDLE = 5'h01;
    localparam S_RX = 5'h02;
    localparam S_ACK = 5'h04;
    localparam S_TX = 5'h08;
    localparam S_TACK = 5'h10;

    // Two-flop synchronisers for every pin
    reg e_m_r, e_s_r, e_d_r;
    reg rs_m_r, rs_s_r, rw_m_r, rw_s_r;
    reg [7:0] db_m_r, db_s_r, db_hold_r;
    reg scl_m_r, scl_s_r, scl_d_r;
    reg sda_m_r, sda_s_r, sda_d_r;
    reg strap_m_r, strap_s_r;

    // Parallel port
    reg nib_first_r;
    reg [3:0] nib_upper_r;
    reg par_push_r;
    reg [9:0] par_word_r;

    // Serial slave
    reg [4:0] i2c_st_r;
    reg [3:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg is_addr_r, rd_mode_r, ctl_done_r, i2c_rs_r, nack_r;
    reg i2c_push_r;
    reg [9:0] i2c_word_r;

    wire e_fall = e_d_r & ~e_s_r;
    wire scl_rise = scl_s_r & ~scl_d_r;
    wire scl_fall = scl_d_r & ~scl_s_r;
    wire start_cond = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    wire stop_cond = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
    wire addr_hit = (shift_r[7:2] == `LCDHP_SLAVE_ADDR_HI) & (shift_r[1] == strap_s_r);

    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [9:0] fifo_out_data;
    wire fifo_pop = fifo_out_valid & std_ready;
    wire [7:0] status_byte = {~fifo_in_ready, 7'h00};

    // Parallel port wins when both ports finish a byte in the same cycle
    wire fifo_push = par_push_r | i2c_push_r;
    wire [9:0] fifo_word = par_push_r ? par_word_r : i2c_word_r;

    always @(posedge clk)
    begin
        e_m_r <= parallel_strobe;
        e_s_r <= e_m_r;
        e_d_r <= e_s_r;
        rs_m_r <= instr_data_select;
        rs_s_r <= rs_m_r;
        rw_m_r <= par_read_write;
        rw_s_r <= rw_m_r;
        db_m_r <= parallel_data_bus_in;
        db_s_r <= db_m_r;
        scl_m_r <= scl_in;
        scl_s_r <= scl_m_r;
        scl_d_r <= scl_s_r;
        sda_m_r <= sda_in;
        sda_s_r <= sda_m_r;
        sda_d_r <= sda_s_r;
        strap_m_r <= addr_low_strap;
        strap_s_r <= strap_m_r;
        if (e_s_r)
        begin
            db_hold_r <= db_s_r;
        end
    end

    // Parallel port: byte taken on the falling strobe edge
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            nib_first_r <= 1'b1;
            nib_upper_r <= 4'h0;
            par_push_r <= 1'b0;
            par_word_r <= 10'h000;
            parallel_data_bus_out <= 8'h00;
            parallel_data_bus_oe <= 1'b0;
        end
        else
        begin
            par_push_r <= 1'b0;
            if (e_fall & ~rw_s_r)
            begin
                if (bus_8bit)
                begin
                    par_push_r <= 1'b1;
                    par_word_r <= {rs_s_r, 1'b0, db_hold_r};
                end
                else if (nib_first_r)
                begin
                    nib_upper_r <= db_hold_r[7:4];
                    nib_first_r <= 1'b0;
                end
                else
                begin
                    par_push_r <= 1'b1;
                    par_word_r <= {rs_s_r, 1'b0, nib_upper_r, db_hold_r[7:4]};
                    nib_first_r <= 1'b1;
                end
            end
            else if (e_fall & rw_s_r & ~bus_8bit)
            begin
                nib_first_r <= ~nib_first_r;
            end
            // Read returns the status byte; lines 3..0 are unused in 4-bit width
            parallel_data_bus_oe <= e_s_r & rw_s_r;
            if (bus_8bit)
            begin
                parallel_data_bus_out <= status_byte;
            end
            else
            begin
                parallel_data_bus_out <= nib_first_r ? {status_byte[7:4], 4'h0} :
                    {status_byte[3:0], 4'h0};
            end
        end
    end

    // Serial slave; only SDA is ever driven, never SCL
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            i2c_st_r <= S_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            is_addr_r <= 1'b0;
            rd_mode_r <= 1'b0;
            ctl_done_r <= 1'b0;
            i2c_rs_r <= 1'b0;
            nack_r <= 1'b0;
            i2c_push_r <= 1'b0;
            i2c_word_r <= 10'h000;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            i2c_push_r <= 1'b0;
            sda_out <= 1'b0;
            if (start_cond)
            begin
                i2c_st_r <= S_RX;
                bit_cnt_r <= 4'h0;
                is_addr_r <= 1'b1;
                ctl_done_r <= 1'b0;
                sda_oe <= 1'b0;
            end
            else if (stop_cond)
            begin
                i2c_st_r <= S_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (i2c_st_r)
                    S_IDLE:
                    begin
                        sda_oe <= 1'b0;
                    end
                    S_RX:
                    begin
                        if (scl_rise)
                        begin
                            shift_r <= {shift_r[6:0], sda_s_r};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                        else if (scl_fall & (bit_cnt_r == 4'h8))
                        begin
                            if (is_addr_r)
                            begin
                                if (addr_hit)
                                begin
                                    rd_mode_r <= shift_r[0];
                                    sda_oe <= 1'b1;
                                    i2c_st_r <= S_ACK;
                                end
                                else
                                begin
                                    i2c_st_r <= S_IDLE;
                                end
                            end
                            else
                            begin
                                if (ctl_done_r)
                                begin
                                    i2c_push_r <= 1'b1;
                                    i2c_word_r <= {i2c_rs_r, 1'b0, shift_r};
                                end
                                else
                                begin
                                    i2c_rs_r <= shift_r[`LCDHP_I2C_CTL_RS];
                                    ctl_done_r <= 1'b1;
                                end
                                sda_oe <= 1'b1;
                                i2c_st_r <= S_ACK;
                            end
                        end
                    end
                    S_ACK:
                    begin
                        if (scl_fall)
                        begin
                            bit_cnt_r <= 4'h0;
                            is_addr_r <= 1'b0;
                            if (rd_mode_r)
                            begin
                                shift_r <= status_byte;
                                sda_oe <= ~status_byte[7];
                                i2c_st_r <= S_TX;
                            end
                            else
                            begin
                                sda_oe <= 1'b0;
                                i2c_st_r <= S_RX;
                            end
                        end
                    end
                    S_TX:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt_r == 4'h7)
                            begin
                                sda_oe <= 1'b0;
                                i2c_st_r <= S_TACK;
                            end
                            else
                            begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                sda_oe <= ~shift_r[6];
                                bit_cnt_r <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    S_TACK:
                    begin
                        if (scl_rise)
                        begin
                            nack_r <= sda_s_r;
                        end
                        else if (scl_fall)
                        begin
                            if (nack_r)
                            begin
                                sda_oe <= 1'b0;
                                i2c_st_r <= S_IDLE;
                            end
                            else
                            begin
                                shift_r <= status_byte;
                                sda_oe <= ~status_byte[7];
                                bit_cnt_r <= 4'h0;
                                i2c_st_r <= S_TX;
                            end
                        end
                    end
                    default:
                    begin
                        i2c_st_r <= S_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    lcdhp_fifo #(
        .W(`LCDHP_FIFO_W),
        .D(`LCDHP_FIFO_D),
        .AW(`LCDHP_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_word),
        .out_valid(fifo_out_valid),
        .out_ready(std_ready),
        .out_data(fifo_out_data)
    );

    // Shared decoder
    wire [7:0] dbyte = fifo_out_data[7:0];
    wire dwrite_instr = ~fifo_out_data[9] & ~fifo_out_data[8];
    wire is_temp = extended_set_select & (dbyte[7:2] == `LCDHP_TEMP_OPC);
    wire is_mult = extended_set_select & (dbyte[7:2] == `LCDHP_MULT_OPC);
    wire is_vf = extended_set_select & dbyte[`LCDHP_VF_MSB];
    wire is_fset = dbyte[7:5] == `LCDHP_FSET_OPC;
    wire is_icon = ~extended_set_select & (dbyte[7:3] == `LCDHP_ICON_OPC);
    wire is_ext = dwrite_instr & (is_temp | is_mult | is_vf);
    wire [5:0] sel_factor = icon_only_select ? icon_mode_voltage_factor :
        char_mode_voltage_factor;

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            std_instr_valid <= 1'b0;
            std_instr_byte <= 8'h00;
            std_instr_rs <= 1'b0;
            std_instr_rw <= 1'b0;
            temp_coeff_sel <= `LCDHP_TC_RST;
            multiplier_stage_sel <= `LCDHP_STAGE_RST;
            char_mode_voltage_factor <= `LCDHP_VF_RST;
            icon_mode_voltage_factor <= `LCDHP_VF_RST;
            icon_only_select <= 1'b0;
            extended_set_select <= 1'b0;
            bus_8bit <= `LCDHP_BUS8_RST;
            lcd_drive_voltage_out <= `LCDHP_VF_RST;
            vgen_enable <= 1'b0;
            busy_flag <= 1'b0;
        end
        else
        begin
            std_instr_valid <= 1'b0;
            busy_flag <= ~fifo_in_ready;
            if (fifo_pop)
            begin
                if (is_ext)
                begin
                    if (is_temp)
                    begin
                        temp_coeff_sel <= dbyte[1:0];
                    end
                    else if (is_mult)
                    begin
                        if (dbyte[1:0] != `LCDHP_STAGE_FORBID)
                        begin
                            multiplier_stage_sel <= dbyte[1:0];
                        end
                    end
                    else if (dbyte[`LCDHP_VF_SEL])
                    begin
                        icon_mode_voltage_factor <= dbyte[5:0];
                    end
                    else
                    begin
                        char_mode_voltage_factor <= dbyte[5:0];
                    end
                end
                else
                begin
                    std_instr_valid <= 1'b1;
                    std_instr_byte <= dbyte;
                    std_instr_rs <= fifo_out_data[9];
                    std_instr_rw <= fifo_out_data[8];
                    if (dwrite_instr & is_fset)
                    begin
                        extended_set_select <= dbyte[`LCDHP_FSET_EXT];
                        bus_8bit <= dbyte[`LCDHP_FSET_DL];
                    end
                    if (dwrite_instr & is_icon)
                    begin
                        icon_only_select <= dbyte[`LCDHP_ICON_IM];
                    end
                end
            end
            lcd_drive_voltage_out <= sel_factor;
            vgen_enable <= display_on & ~power_down & (sel_factor != 6'h00);
        end
    end
endmodule

/* sim/lcdhp_props.sv */
// Concurrent checks on the outputs of the LCD host port block.
// Assumes binding into lcdhp_top; sees only its ports.
`timescale 1ns/10ps
module lcdhp_props (
    input wire clk,
    input wire sys_rst,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe,
    input wire display_on,
    input wire power_down,
    input wire [1:0] temp_coeff_sel,
    input wire [1:0] multiplier_stage_sel,
    input wire [5:0] char_mode_voltage_factor,
    input wire [5:0] icon_mode_voltage_factor,
    input wire icon_only_select,
    input wire extended_set_select,
    input wire bus_8bit,
    input wire [5:0] lcd_drive_voltage_out,
    input wire vgen_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_reset_values: assert property ($fell(sys_rst) |-> temp_coeff_sel == 2'h0 && bus_8bit)
        else $error("temp coefficient or width wrong after reset");
    a_stage_legal: assert property (multiplier_stage_sel != 2'h3)
        else $error("forbidden stage count taken");
    a_tc_ext: assert property ($changed(temp_coeff_sel) || $changed(multiplier_stage_sel)
        |-> $past(extended_set_select)) else $error("temp or stage changed outside extended set");
    a_vf_ext: assert property ($changed(char_mode_voltage_factor)
        || $changed(icon_mode_voltage_factor) |-> $past(extended_set_select))
        else $error("voltage factor changed outside extended set");
    a_drive_select: assert property ($stable(icon_only_select)
        && $stable(char_mode_voltage_factor) && $stable(icon_mode_voltage_factor)
        |-> lcd_drive_voltage_out == (icon_only_select ? icon_mode_voltage_factor
        : char_mode_voltage_factor)) else $error("drive voltage from wrong factor");
    a_vgen_zero: assert property (lcd_drive_voltage_out == 6'h00
        && $past(lcd_drive_voltage_out) == 6'h00 |-> !vgen_enable)
        else $error("generator on with zero factor");
    a_display_off: assert property (!display_on && !$past(display_on) |-> !vgen_enable)
        else $error("generator on while display off");
    a_power_down: assert property (power_down && $past(power_down) |-> !vgen_enable)
        else $error("generator on in power-down");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("SDA moved while SCL high");
    a_sda_opendrain: assert property (sda_out == 1'b0)
        else $error("SDA driven high");
endmodule

bind lcdhp_top lcdhp_props u_props (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .display_on(display_on), .power_down(power_down), .temp_coeff_sel(temp_coeff_sel),
    .multiplier_stage_sel(multiplier_stage_sel),
    .char_mode_voltage_factor(char_mode_voltage_factor),
    .icon_mode_voltage_factor(icon_mode_voltage_factor),
    .icon_only_select(icon_only_select), .extended_set_select(extended_set_select),
    .bus_8bit(bus_8bit), .lcd_drive_voltage_out(lcd_drive_voltage_out),
    .vgen_enable(vgen_enable)
);

/* sim/lcdhp_host.sv */
// Host model: parallel bus master and two-wire serial master.
// Assumes clk of the block; SDA level is resolved by the bench.
`timescale 1ns/10ps
module lcdhp_host (
    input wire clk,
    output reg strobe = 1'b0,
    output reg rs = 1'b0,
    output reg rw = 1'b0,
    output reg [7:0] db = 8'h00,
    input wire [7:0] dbo,
    output reg scl = 1'b1,
    output reg sda_pull = 1'b0,
    input wire sda
);
    reg w4 = 1'b0;

    task w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // On reads the host drives inverted data; the bench feeds dbo back while oe is set
    task cyc(input logic r_s, input logic r_w, input logic [7:0] d, output logic [7:0] q);
        rs = r_s;
        rw = r_w;
        db = r_w ? ~db : d;
        strobe = 1'b1;
        w(8);
        q = dbo;
        strobe = 1'b0;
        w(8);
    endtask

    // Lines 3..0 are driven high by the host in 4-bit mode
    task xfer(input logic r_s, input logic r_w, input logic [7:0] d, output logic [7:0] q);
        logic [7:0] h;
        if (w4)
        begin
            cyc(r_s, r_w, {d[7:4], 4'hf}, h);
            cyc(r_s, r_w, {d[3:0], 4'hf}, q);
            q = {h[7:4], q[7:4]};
        end
        else
            cyc(r_s, r_w, d, q);
    endtask

    // Called only from an idle bus
    task start;
        sda_pull = 1'b1;
        w(8);
        scl = 1'b0;
        w(2);
    endtask

    task sbit(input logic b, output logic s);
        sda_pull = !b;
        w(6);
        scl = 1'b1;
        w(4);
        s = sda;
        w(4);
        scl = 1'b0;
        w(2);
    endtask

    // MSB first; mack low leaves the ninth bit released (write, or last read)
    task ibyte(input logic [7:0] b, input logic mack, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
            sbit(b[i], r[i]);
        sbit(!mack, ack);
        ack = !ack;
    endtask

    task stop;
        sda_pull = 1'b1;
        w(6);
        scl = 1'b1;
        w(8);
        sda_pull = 1'b0;
        w(8);
    endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the LCD host port block.
// Assumes lcdhp_host drives the pins; checker is bound to lcdhp_top.
`timescale 1ns/10ps
module tb_top;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg addr_low_strap = 1'b0;
    reg display_on = 1'b0;
    reg power_down = 1'b0;
    reg std_ready = 1'b1;
    wire strobe, rs, rw, scl, sda_pull, sda_oe, oe, stv, ext, b8, vgen, busy, icm;
    wire sdo, srs, srw;
    wire [7:0] db, dbo, sb;
    wire [1:0] tc, st;
    wire [5:0] vfa, vfb, vout;
    wire sda = !(sda_oe || sda_pull);
    logic [7:0] q;
    logic a;
    int err_count = 0;
    int n_checks = 0;
    int n_std = 0;

    always #5 clk = ~clk;
    always @(posedge clk)
        if (stv === 1'b1)
            n_std <= n_std + 1;

    lcdhp_top u_dut (
        .clk(clk), .sys_rst(sys_rst), .parallel_strobe(strobe), .instr_data_select(rs),
        .par_read_write(rw), .parallel_data_bus_in(oe ? dbo : db),
        .parallel_data_bus_out(dbo), .parallel_data_bus_oe(oe), .scl_in(scl),
        .sda_in(sda), .sda_out(sdo), .sda_oe(sda_oe), .addr_low_strap(addr_low_strap),
        .display_on(display_on), .power_down(power_down), .std_ready(std_ready),
        .std_instr_valid(stv), .std_instr_byte(sb), .std_instr_rs(srs),
        .std_instr_rw(srw), .temp_coeff_sel(tc), .multiplier_stage_sel(st),
        .char_mode_voltage_factor(vfa), .icon_mode_voltage_factor(vfb),
        .icon_only_select(icm), .extended_set_select(ext), .bus_8bit(b8),
        .lcd_drive_voltage_out(vout), .vgen_enable(vgen), .busy_flag(busy)
    );
    lcdhp_host u_host (
        .clk(clk), .strobe(strobe), .rs(rs), .rw(rw), .db(db), .dbo(dbo), .scl(scl),
        .sda_pull(sda_pull), .sda(sda)
    );

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task finish_test;
        if (err_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task wr(input logic r, input logic [7:0] d);
        u_host.xfer(r, 1'b0, d, q);
        u_host.w(10);
    endtask

    task t_regs;
        chk(tc, 8'h00);
        chk(b8, 8'h01);
        wr(0, 8'h13);
        chk(sb, 8'h13);
        chk(tc, 8'h00);
        wr(0, 8'h31);
        chk(ext, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            wr(0, 8'h10 + 8'(i));
            chk(tc, 8'(i));
        end
        for (int i = 0; i < 3; i++)
        begin
            wr(0, 8'h40 + 8'(i));
            chk(st, 8'(i));
        end
        wr(0, 8'h43);
        chk(st, 8'h02);
        wr(0, 8'hAA);
        wr(0, 8'hD5);
        chk(vfa, 8'h2a);
        chk(vfb, 8'h15);
        wr(0, 8'h30);
        chk(ext, 8'h00);
    endtask

    task t_vgen;
        display_on = 1'b1;
        u_host.w(4);
        chk(vout, 8'h2a);
        chk(vgen, 8'h01);
        wr(0, 8'h0C);
        chk(vout, 8'h15);
        power_down = 1'b1;
        u_host.w(4);
        chk(vgen, 8'h00);
        power_down = 1'b0;
        display_on = 1'b0;
        u_host.w(4);
        chk(vgen, 8'h00);
        display_on = 1'b1;
        wr(0, 8'h31);
        wr(0, 8'hC0);
        wr(0, 8'h30);
        chk(vout, 8'h00);
        chk(vgen, 8'h00);
    endtask

    task t_nibble;
        wr(0, 8'h20);
        chk(b8, 8'h00);
        u_host.w4 = 1'b1;
        wr(1, 8'h5A);
        chk(sb, 8'h5a);
        chk(srs, 8'h01);
        chk(srw, 8'h00);
        u_host.xfer(0, 1'b1, 8'h00, q);
        chk(q, 8'h00);
        chk(oe, 8'h00);
        wr(0, 8'h30);
        chk(b8, 8'h01);
        u_host.w4 = 1'b0;
    endtask

    task t_serial;
        u_host.start;
        u_host.ibyte(8'h74, 0, q, a);
        chk(a, 8'h01);
        u_host.ibyte(8'h00, 0, q, a);
        u_host.ibyte(8'hA5, 0, q, a);
        chk(a, 8'h01);
        u_host.stop;
        u_host.w(10);
        chk(sb, 8'ha5);
        chk(srs, 8'h00);
        chk(sdo, 8'h00);
        u_host.start;
        u_host.ibyte(8'h76, 0, q, a);
        chk(a, 8'h00);
        u_host.stop;
        addr_low_strap = 1'b1;
        u_host.w(4);
        u_host.start;
        u_host.ibyte(8'h77, 0, q, a);
        chk(a, 8'h01);
        u_host.ibyte(8'hFF, 0, q, a);
        chk(q, 8'h00);
        u_host.w(4);
        chk(sda, 8'h01);
        u_host.stop;
    endtask

    task t_fifo;
        int base;
        base = n_std;
        std_ready = 1'b0;
        for (int i = 0; i < 17; i++)
            wr(1, 8'(i));
        chk(busy, 8'h01);
        std_ready = 1'b1;
        for (int k = 0; k < 400 && n_std - base < 16; k++)
            u_host.w(1);
        if (n_std - base < 16)
        begin
            err_count++;
            finish_test;
        end
        u_host.w(5);
        chk(8'(n_std - base), 8'h10);
        chk(sb, 8'h0f);
        chk(busy, 8'h00);
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        u_host.w(4);
        t_regs;
        t_vgen;
        t_nibble;
        t_serial;
        t_fifo;
        finish_test;
    end
endmodule
